// >>> hw/acp_adc_port.sv
// Conversion sequencer and shared parallel/serial output port.
// Assumes sar_code is stable on clk and configuration pins are static
// while the serial link runs; serial_clk_in is the host's clock.
`default_nettype none

module acp_adc_port
   import acp_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic serial_clk_in,
   input wire acp_cfg_t cfg,
   input wire logic convert_start_n,
   input wire logic chip_select_n,
   input wire logic read_strobe_n,
   input wire logic power_down,
   input wire logic [RES_W-1:0] sar_code,
   output logic [RES_W-1:0] data_out,
   output logic [RES_W-1:0] data_oe,
   output logic busy,
   output logic low_power
);

   localparam int IN_W = $bits(acp_cfg_t) + 3;

   function automatic logic [RES_W-1:0] apply_coding(
      input logic [RES_W-1:0] code,
      input logic straight);
      apply_coding = straight ? code : {~code[MSB], code[MSB-1:0]};
   endfunction : apply_coding

   // Pin synchronisers, clk domain
   logic rd_en_raw;
   logic [IN_W-1:0] in_s1_reg;
   logic [IN_W-1:0] in_s2_reg;
   logic cnv_prev_reg;
   acp_cfg_t cfg_s;
   logic cnv_s;
   logic rd_en_s;
   logic pd_s;

   // Both strobes are ORed before they are sampled
   assign rd_en_raw = ~(chip_select_n | read_strobe_n);

   always_ff @(posedge clk) begin
      in_s1_reg <= {cfg, convert_start_n, rd_en_raw, power_down};
      in_s2_reg <= in_s1_reg;
      cnv_prev_reg <= in_s2_reg[2];
   end

   assign cfg_s = acp_cfg_t'(in_s2_reg[IN_W-1:3]);
   assign cnv_s = in_s2_reg[2];
   assign rd_en_s = in_s2_reg[1];
   assign pd_s = in_s2_reg[0];

   // Mode decode
   logic ser_mode;
   logic ext_mode;
   logic master_mode;
   logic slave_mode;
   assign ser_mode = cfg_s.serial_parallel_select;
   assign ext_mode = cfg_s.clock_source_select;
   assign master_mode = ser_mode & ~ext_mode;
   assign slave_mode = ser_mode & ext_mode;

   // Conversion sequencer
   acp_state_t state_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic cnv_fall;
   logic acq_end;
   logic conv_start;
   logic conv_done;

   assign cnv_fall = cnv_prev_reg & ~cnv_s;
   assign acq_end = (state_reg == ST_ACQ) && (cnt_reg == ACQ_LAST);
   assign conv_done = (state_reg == ST_CONV) && (cnt_reg == CONV_LAST);
   assign conv_start = ~pd_s &&
      ((acq_end && ~cnv_s) || (state_reg == ST_WAIT && cnv_fall));

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= ST_ACQ;
         cnt_reg <= CNT_ZERO;
      end else begin
         unique case (state_reg)
            ST_ACQ: begin
               if (pd_s) begin
                  state_reg <= ST_PD;
                  cnt_reg <= CNT_ZERO;
               end else if (acq_end) begin
                  cnt_reg <= CNT_ZERO;
                  // Start already low skips the edge wait
                  state_reg <= cnv_s ? ST_WAIT : ST_CONV;
               end else begin
                  cnt_reg <= cnt_reg + CNT_ONE;
               end
            end
            ST_WAIT: begin
               if (pd_s) begin
                  state_reg <= ST_PD;
               end else if (cnv_fall) begin
                  state_reg <= ST_CONV;
                  cnt_reg <= CNT_ZERO;
               end
            end
            ST_CONV: begin
               // Power down is not looked at until the result is in
               if (conv_done) begin
                  state_reg <= ST_ACQ;
                  cnt_reg <= CNT_ZERO;
               end else begin
                  cnt_reg <= cnt_reg + CNT_ONE;
               end
            end
            ST_PD: begin
               if (~pd_s) begin
                  state_reg <= ST_ACQ;
                  cnt_reg <= CNT_ZERO;
               end
            end
         endcase
      end
   end

   // Busy, result latch and handoff toggle to the link domain
   logic busy_reg;
   logic low_power_reg;
   logic [RES_W-1:0] result_reg;
   logic ready_tog_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         busy_reg <= 1'b0;
      end else if (conv_start) begin
         busy_reg <= 1'b1;
      end else if (conv_done) begin
         busy_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         result_reg <= ALL_OFF;
         ready_tog_reg <= 1'b0;
      end else if (conv_done) begin
         result_reg <= apply_coding(sar_code,
            cfg_s.output_coding_select);
         ready_tog_reg <= ~ready_tog_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         low_power_reg <= 1'b0;
      end else begin
         low_power_reg <= (state_reg == ST_PD);
      end
   end

   // Master serial sequencer: the device makes the clock
   logic m_pend_reg;
   logic m_act_reg;
   logic [1:0] m_ph_reg;
   logic [BIT_W-1:0] m_bit_reg;
   logic [RES_W-1:0] m_shift_reg;
   logic m_sdo_reg;
   logic m_sclk_reg;
   logic m_trig;
   logic m_go;

   // Chain pin picks read during conversion or after it
   assign m_trig = master_mode &&
      (cfg_s.read_mode_or_chain_in ? conv_start : conv_done);
   assign m_go = m_pend_reg && ~m_act_reg && rd_en_s;

   always_ff @(posedge clk) begin
      if (rst) begin
         m_pend_reg <= 1'b0;
      end else if (m_trig) begin
         m_pend_reg <= 1'b1;
      end else if (m_go || ~master_mode) begin
         m_pend_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         m_act_reg <= 1'b0;
         m_ph_reg <= PH_DATA;
         m_bit_reg <= BIT_ZERO;
         m_shift_reg <= ALL_OFF;
         m_sdo_reg <= 1'b0;
         m_sclk_reg <= 1'b0;
      end else if (m_go) begin
         m_act_reg <= 1'b1;
         m_ph_reg <= PH_DATA;
         m_bit_reg <= BIT_ZERO;
         m_shift_reg <= result_reg;
      end else if (m_act_reg) begin
         if (~rd_en_s || ~master_mode) begin
            m_act_reg <= 1'b0;
            m_sclk_reg <= 1'b0;
         end else begin
            m_ph_reg <= m_ph_reg + PH_STEP;
            if (m_ph_reg == PH_DATA) begin
               // Data changes a phase away from either clock edge
               m_sdo_reg <= m_shift_reg[MSB];
               m_shift_reg <= {m_shift_reg[MSB-1:0], 1'b0};
            end else if (m_ph_reg == PH_RISE) begin
               m_sclk_reg <= 1'b1;
            end else if (m_ph_reg == PH_FALL) begin
               m_sclk_reg <= 1'b0;
               if (m_bit_reg == BIT_LAST) begin
                  m_act_reg <= 1'b0;
               end else begin
                  m_bit_reg <= m_bit_reg + BIT_ONE;
               end
            end
         end
      end
   end

   // Slave serial logic on the host's clock
   logic lclk;
   logic l_rst1_reg;
   logic l_rst2_reg;
   logic l_rd1_reg;
   logic l_rd2_reg;
   logic l_rd3_reg;
   logic l_tg1_reg;
   logic l_tg2_reg;
   logic l_tg3_reg;
   logic l_act_reg;
   logic [BIT_W-1:0] l_cnt_reg;
   logic [RES_W-1:0] l_shift_reg;
   logic l_sdo_reg;
   logic l_open_reg;

   // Inverting the clock swaps the edge the data changes on
   assign lclk = serial_clk_in ^ cfg.serial_clock_invert;

   always_ff @(posedge lclk) begin
      l_rst1_reg <= rst;
      l_rst2_reg <= l_rst1_reg;
      l_rd1_reg <= rd_en_raw;
      l_rd2_reg <= l_rd1_reg;
      l_rd3_reg <= l_rd2_reg;
      l_tg1_reg <= ready_tog_reg;
      l_tg2_reg <= l_tg1_reg;
      l_tg3_reg <= l_tg2_reg;
   end

   // result_reg is quiet while the toggle crosses, so it is read directly
   always_ff @(posedge lclk) begin
      if (l_rst2_reg) begin
         l_act_reg <= 1'b0;
         l_cnt_reg <= BIT_ZERO;
         l_shift_reg <= ALL_OFF;
         l_sdo_reg <= 1'b0;
      end else if (l_act_reg && (l_tg3_reg != l_tg2_reg) &&
                   (l_cnt_reg < BIT_WORD)) begin
         l_act_reg <= 1'b0;
      end else if (~l_act_reg && l_rd2_reg && ~l_rd3_reg) begin
         l_act_reg <= 1'b1;
         l_cnt_reg <= BIT_ONE;
         l_sdo_reg <= result_reg[MSB];
         l_shift_reg <= {result_reg[MSB-1:0],
            cfg.read_mode_or_chain_in};
      end else if (l_act_reg) begin
         if (~l_rd2_reg) begin
            l_act_reg <= 1'b0;
         end else begin
            // Chain bits follow the word, so reads may run past 16
            l_sdo_reg <= l_shift_reg[MSB];
            l_shift_reg <= {l_shift_reg[MSB-1:0],
               cfg.read_mode_or_chain_in};
            if (l_cnt_reg < BIT_WORD) begin
               l_cnt_reg <= l_cnt_reg + BIT_ONE;
            end
         end
      end
   end

   always_ff @(posedge lclk) begin
      if (l_rst2_reg) begin
         l_open_reg <= 1'b0;
      end else begin
         l_open_reg <= l_act_reg && (l_cnt_reg < BIT_WORD);
      end
   end

   // Unfinished-read level back into clk
   logic open_s1_reg;
   logic open_s2_reg;

   always_ff @(posedge clk) begin
      open_s1_reg <= l_open_reg;
      open_s2_reg <= open_s1_reg;
   end

   // Shared pins
   logic [RES_W-1:0] pin_reg;
   logic [RES_W-1:0] oe_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         pin_reg <= ALL_OFF;
         oe_reg <= ALL_OFF;
      end else if (~ser_mode) begin
         pin_reg <= result_reg;
         oe_reg <= rd_en_s ? ALL_ON : ALL_OFF;
      end else begin
         pin_reg <= ALL_OFF;
         pin_reg[MSB:HI_LSB] <= result_reg[MSB:HI_LSB];
         pin_reg[SDO_BIT] <= m_sdo_reg;
         pin_reg[SCLK_BIT] <= master_mode &&
            (m_sclk_reg ^ cfg_s.serial_clock_invert);
         pin_reg[FSYNC_BIT] <= (master_mode && m_act_reg) ^
            cfg_s.frame_sync_polarity;
         pin_reg[OVR_BIT] <= slave_mode && conv_done &&
            open_s2_reg;
         // Slave mode takes the clock in on pin 9
         oe_reg <= ~rd_en_s ? ALL_OFF :
            master_mode ? (HI_NIBBLE | SER_PINS) :
            (HI_NIBBLE | SER_PINS) & ~(RES_W'(1) << SCLK_BIT);
      end
   end

   // Slave data bit comes from the link flop, everything else from clk
   always_comb begin
      data_out = pin_reg;
      data_out[SDO_BIT] = slave_mode ? l_sdo_reg : pin_reg[SDO_BIT];
   end

   assign data_oe = oe_reg;
   assign busy = busy_reg;
   assign low_power = low_power_reg;

endmodule : acp_adc_port

`default_nettype wire

// >>> hw/acp_pkg.sv
// Constants, types and mode encodings for the converter control and port.
// Assumes a 10 MHz system clock and a host that clocks the serial link.
// Function
// - Pin 9 carries bit 9, else serial clock out (internal) or in (external).
// - Pin 10 carries bit 10, else frame sync output for internal clocking.
// - Frame sync active high when polarity low, active low when polarity high.
// - Pin 11 carries bit 11, else incomplete-read flag with external clock.
// - Slave read unfinished at next conversion end: data lost, flag pulsed.
// - Result bits 12 to 15 are outputs in both serial and parallel mode.
// - Busy rises at conversion start, falls once the result is latched.
// - Output bus enabled only while chip select and read strobe are both low.
// - Reset high returns to reset state and aborts any conversion.
// - Power down lets the current conversion finish, then blocks new ones.
// - Start high at end of acquisition: wait for its falling edge.
// - Start already low at end of acquisition: convert at once.
// - External clock: data changes on rising edge, swapped when inverted.
// - Result shifts out MSB first, coded per coding select input.
// - External clock: chain input reappears on data out 16 periods later.
// - Internal clock: chain pin high reads during conversion, low after.
`default_nettype none

package acp_pkg;

   localparam int RES_W = 16;
   localparam int CLK_NS = 100;
   // Acquisition and conversion times in ns, rounded up to whole cycles
   localparam int T_ACQ_NS = 1000;
   localparam int T_CONV_NS = 8000;
   localparam int ACQ_CYC = (T_ACQ_NS + CLK_NS - 1) / CLK_NS;
   localparam int CONV_CYC = (T_CONV_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] ACQ_LAST = CNT_W'(ACQ_CYC - 1);
   localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYC - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

   // Serial word length and bit counter
   localparam int BIT_W = 5;
   localparam logic [BIT_W-1:0] BIT_LAST = 5'h0F;
   localparam logic [BIT_W-1:0] BIT_WORD = 5'h10;
   localparam logic [BIT_W-1:0] BIT_ZERO = 5'h00;
   localparam logic [BIT_W-1:0] BIT_ONE = 5'h01;

   // Master serial clock: four system cycles per bit
   localparam logic [1:0] PH_DATA = 2'h0;
   localparam logic [1:0] PH_RISE = 2'h1;
   localparam logic [1:0] PH_FALL = 2'h3;
   localparam logic [1:0] PH_STEP = 2'h1;

   // Pin positions on the shared data bus
   localparam int SDO_BIT = 8;
   localparam int SCLK_BIT = 9;
   localparam int FSYNC_BIT = 10;
   localparam int OVR_BIT = 11;
   localparam int HI_LSB = 12;
   localparam int MSB = RES_W - 1;
   localparam logic [RES_W-1:0] ALL_ON = 16'hFFFF;
   localparam logic [RES_W-1:0] ALL_OFF = 16'h0000;
   localparam logic [RES_W-1:0] HI_NIBBLE = 16'hF000;
   localparam logic [RES_W-1:0] SER_PINS = 16'h0F00;

   typedef struct packed {
      logic serial_parallel_select;
      logic clock_source_select;
      logic serial_clock_invert;
      logic frame_sync_polarity;
      logic output_coding_select;
      logic read_mode_or_chain_in;
   } acp_cfg_t;

   typedef enum logic [1:0] {
      ST_ACQ,
      ST_WAIT,
      ST_CONV,
      ST_PD
   } acp_state_t;

endpackage : acp_pkg

`default_nettype wire

// >>> testbench/acp_port_properties.sv
// Port checker for the converter sequencer and shared output port.
// Assumes cfg is held still while a transfer is being checked.
`default_nettype none
module acp_port_properties
   import acp_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic serial_clk_in,
   input wire acp_cfg_t cfg,
   input wire logic convert_start_n,
   input wire logic chip_select_n,
   input wire logic read_strobe_n,
   input wire logic power_down,
   input wire logic [RES_W-1:0] sar_code,
   input wire logic [RES_W-1:0] data_out,
   input wire logic [RES_W-1:0] data_oe,
   input wire logic busy,
   input wire logic low_power
);
   timeunit 1ns;
   timeprecision 1ps;
   acp_cfg_t cfg_reg;
   logic [2:0] age_reg;
   logic [7:0] busy_cnt_reg;
   logic [6:0] frame_cnt_reg;
   logic quiet, master, slave, sync_act, hi;
   assign quiet = age_reg == 3'h7;
   assign master = cfg.serial_parallel_select && !cfg.clock_source_select;
   assign slave = cfg.serial_parallel_select && cfg.clock_source_select;
   assign sync_act = data_out[FSYNC_BIT] ^ cfg.frame_sync_polarity;
   assign hi = chip_select_n | read_strobe_n;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Config is synchronised late, so checks wait until it has settled
   always_ff @(posedge clk) begin
      cfg_reg <= cfg;
      if (rst || cfg != cfg_reg) age_reg <= 3'h0;
      else if (!quiet) age_reg <= age_reg + 3'h1;
   end
   always_ff @(posedge clk) begin
      busy_cnt_reg <= (rst || !busy) ? 8'h00 : busy_cnt_reg + 8'h01;
   end
   always_ff @(posedge clk) begin
      frame_cnt_reg <= (rst || !sync_act) ? 7'h00 : frame_cnt_reg + 7'h01;
   end
   AST_RST_IDLE: assert property (disable iff (1'b0)
      rst |=> !busy && !low_power && data_oe == ALL_OFF)
      else $error("outputs not idle after reset");
   AST_BUSY_LEN: assert property (quiet && $fell(busy)
      |-> busy_cnt_reg == 8'h50) else $error("busy length wrong");
   AST_ACQ_GAP: assert property ($fell(busy) |-> !busy [*8])
      else $error("conversion restarted without acquisition");
   AST_START_CAUSE: assert property ($rose(busy)
      |-> !$past(convert_start_n, 2)) else $error("busy without start");
   AST_PD_IDLE: assert property (low_power |-> !busy)
      else $error("conversion during power down");
   AST_PD_FINISH: assert property (busy && power_down
      && busy_cnt_reg < 8'h4F |=> busy) else $error("conversion cut short");
   AST_OE_IDLE: assert property (quiet && !cfg.serial_parallel_select
      && $past(hi, 2) && $past(hi, 3) && $past(hi, 4) |-> data_oe == ALL_OFF)
      else $error("bus driven without read");
   AST_OE_READ: assert property (quiet && !cfg.serial_parallel_select
      && !$past(hi, 2) && !$past(hi, 3) && !$past(hi, 4)
      |-> data_oe == ALL_ON) else $error("bus not driven on read");
   AST_SCLK_DIR: assert property (quiet && slave
      |-> !data_oe[SCLK_BIT]) else $error("slave drives serial clock");
   AST_FRAME_LEN: assert property (quiet && master && $fell(sync_act)
      |-> frame_cnt_reg == 7'h40) else $error("frame sync length wrong");
   AST_OVR_PULSE: assert property (quiet && slave
      && $rose(data_out[OVR_BIT]) |-> !busy && ($past(busy, 2)
      || $past(busy, 3)) ##1 !data_out[OVR_BIT])
      else $error("overrun pulse misplaced");
endmodule : acp_port_properties
`default_nettype wire

// >>> testbench/acp_link_host.sv
// Host side of the serial link: makes the link clock for slave reads.
// Assumes the bench opens and closes each frame through run.
`default_nettype none
module acp_link_host (
   input wire logic run,
   output var logic sclk
);
   timeunit 1ns;
   timeprecision 1ps;
   // Odd offset keeps the link unrelated in phase to clk
   initial begin
      sclk = 1'b0;
      #13;
      forever begin
         #40;
         // Clock stands low between frames
         sclk = run ? ~sclk : 1'b0;
      end
   end
endmodule : acp_link_host
`default_nettype wire

// >>> testbench/tb_adc_conversion_and_output_port.sv
// Bench for the converter port: conversions, parallel and serial reads.
// Assumes the link host model supplies the slave clock.
`default_nettype none
module tb_adc_conversion_and_output_port;
   import acp_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, run, sclk, convert_start_n, chip_select_n, read_strobe_n;
   logic power_down, busy, low_power, prev, s, bad;
   acp_cfg_t cfg;
   logic [RES_W-1:0] sar_code, data_out, data_oe, bits, ocnt;
   logic [18:0] sh;
   int failures, samples_checked, n;
   acp_adc_port acp_adc_port_i (.clk(clk), .rst(rst), .serial_clk_in(sclk),
      .cfg(cfg), .convert_start_n(convert_start_n),
      .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
      .power_down(power_down), .sar_code(sar_code), .data_out(data_out),
      .data_oe(data_oe), .busy(busy), .low_power(low_power));
   acp_link_host acp_link_host_i (.run(run), .sclk(sclk));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task test_done;
      if (failures == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : test_done
   task chk(input logic [RES_W-1:0] got, input logic [RES_W-1:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t ns got %h want %h", $time, got, exp);
      end
   endtask : chk
   task tick(input int k);
      repeat (k) @(posedge clk);
   endtask : tick
   task wait_busy(input logic lvl);
      int i;
      i = 0;
      do begin
         @(negedge clk);
         i++;
      end while (busy !== lvl && i < 300);
      if (busy !== lvl) begin
         failures++;
         $display("[FAIL] %0t ns busy wait ran out", $time);
         test_done;
      end
      @(posedge clk);
   endtask : wait_busy
   task convert(input logic [RES_W-1:0] code);
      @(posedge clk);
      sar_code <= code;
      convert_start_n <= 1'b0;
      wait_busy(1'b1);
      convert_start_n <= 1'b1;
      wait_busy(1'b0);
   endtask : convert
   task strobe(input logic cs, input logic rd);
      @(posedge clk);
      chip_select_n <= cs;
      read_strobe_n <= rd;
      tick(3);
      @(negedge clk);
   endtask : strobe
   task setcfg(input acp_cfg_t c);
      @(posedge clk);
      cfg <= c;
      tick(6);
   endtask : setcfg
   initial begin
      {rst, run, convert_start_n, chip_select_n, read_strobe_n} = 5'h1F;
      {power_down, failures, samples_checked} = '0;
      cfg = '0;
      sar_code = '0;
      tick(3);
      {rst, run} <= 2'h0;
      @(negedge clk);
      chk(data_oe, ALL_OFF);
      for (int k = 0; k < 2; k++) begin
         setcfg({4'h0, k[0], 1'b0});
         convert(16'hA5C3);
         strobe(1'b0, 1'b0);
         chk(data_oe, ALL_ON);
         chk(data_out, k ? 16'hA5C3 : 16'h25C3);
         strobe(1'b1, 1'b1);
         chk(data_oe, ALL_OFF);
      end
      strobe(1'b0, 1'b1);
      chk(data_oe, ALL_OFF);
      strobe(1'b1, 1'b1);
      tick(20);
      chk({15'h0000, busy}, 16'h0000);
      @(posedge clk);
      convert_start_n <= 1'b0;
      wait_busy(1'b1);
      convert_start_n <= 1'b1;
      tick(10);
      {rst, run} <= 2'h3;
      tick(3);
      {rst, run} <= 2'h0;
      @(negedge clk);
      chk({15'h0000, busy}, 16'h0000);
      @(posedge clk);
      convert_start_n <= 1'b0;
      wait_busy(1'b1);
      {power_down, convert_start_n} <= 2'h3;
      wait_busy(1'b0);
      convert_start_n <= 1'b0;
      tick(30);
      @(negedge clk);
      chk({busy, low_power}, 16'h0001);
      @(posedge clk);
      {power_down, convert_start_n} <= 2'h1;
      // Master reads with both frame sync senses and clock senses
      for (int p = 0; p < 2; p++) begin
         setcfg({2'h2, p[0], p[0], 2'h2});
         convert(16'hC35A);
         strobe(1'b0, 1'b0);
         {n, bad, prev} = '0;
         for (int i = 0; i < 400 && n < 16; i++) begin
            @(negedge clk);
            s = data_out[SCLK_BIT] ^ p[0];
            if (s && !prev) begin
               bits = {bits[14:0], data_out[SDO_BIT]};
               bad |= data_out[FSYNC_BIT] !== !p[0];
               n++;
            end
            prev = s;
         end
         chk(bits, 16'hC35A);
         chk({15'h0000, bad}, 16'h0000);
         tick(8);
         strobe(1'b1, 1'b1);
      end
      setcfg(6'h33);
      convert(16'h9E61);
      strobe(1'b0, 1'b0);
      run <= 1'b1;
      for (int i = 0; i < 19; i++) begin
         @(negedge sclk);
         sh = {sh[17:0], data_out[SDO_BIT]};
      end
      chk(sh[16:1], 16'h9E61);
      chk({15'h0000, sh[0]}, 16'h0001);
      strobe(1'b1, 1'b1);
      run <= 1'b0;
      // Partial slave read, then a conversion ends under it
      strobe(1'b0, 1'b0);
      run <= 1'b1;
      tick(6);
      run <= 1'b0;
      convert_start_n <= 1'b0;
      ocnt = '0;
      for (int i = 0; i < 120; i++) begin
         @(negedge clk);
         convert_start_n <= busy;
         ocnt += data_out[OVR_BIT];
      end
      chk(ocnt, 16'h0001);
      strobe(1'b1, 1'b1);
      test_done;
   end
endmodule : tb_adc_conversion_and_output_port
bind acp_adc_port acp_port_properties acp_port_properties_i (.clk, .rst,
   .serial_clk_in, .cfg, .convert_start_n, .chip_select_n, .read_strobe_n,
   .power_down, .sar_code, .data_out, .data_oe, .busy, .low_power);
`default_nettype wire
